// >>> acs_top.sv
// Purpose: sample clock source selection, pitch and word clock output
// Assumes: input ticks are one-cycle pulses synchronous to MCLK
// Notes: word clock out is a one-cycle pulse per word clock period
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module acs_top #(
	parameter int GATE_CYC = acs_pkg::CLK_HZ
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// axi4-lite write
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output var  logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output var  logic        WREADY,
	output var  logic [1:0]  BRESP,
	output var  logic        BVALID,
	input  wire logic        BREADY,
	// axi4-lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output var  logic        ARREADY,
	output var  logic [31:0] RDATA,
	output var  logic [1:0]  RRESP,
	output var  logic        RVALID,
	input  wire logic        RREADY,
	// recovered inputs: word, optical, coax, timecode
	input  wire logic [3:0]  SRC_VALID,
	input  wire logic [3:0]  SRC_TICK,
	input  wire logic        OPT2_VALID,
	input  wire logic        OPT2_TICK,
	// clock outputs and state
	output var  logic        SAMPLE_TICK,
	output var  logic        WCK_OUT,
	output var  logic        OPT2_OUT_SPDIF,
	output var  logic        MASTER,
	output var  logic [2:0]  ACTIVE_SRC
);
	localparam int RW = acs_pkg::RATE_W;

	logic [8:0]           ctrl_reg;
	logic [RW-1:0]        base_reg;
	logic signed [19:0]   fine_reg;
	logic [28:0]          acc_reg;
	logic [31:0]          gate_cnt_reg;
	logic [8:0]           gap_reg;
	logic [1:0]           wdiv_reg;
	logic                 aw_have_reg, w_have_reg;
	logic [7:0]           aw_addr_reg;
	logic [31:0]          w_data_reg;
	acs_pkg::acs_src_e    pref, sel_next, act;
	acs_pkg::acs_pre_e    preset;
	logic [3:0]           ext_valid, ext_tick;
	logic [RW-1:0]        meas [4];
	logic [1:0]           lock_st [4];
	logic [RW-1:0]        lim_u, pre_u, cur_rate, int_rate;
	logic signed [19:0]   lim_s, pre_s, tot_s, fine_next;
	logic [28:0]          acc_sum;
	logic                 dds_tick, chosen_tick, gate, pass_tick;
	logic [2:0]           wdiv_max;
	logic                 found, wr_fire;
	logic [1:0]           idx;
	logic [31:0]          rd_data;
	logic                 rd_ok;

	assign pref   = acs_pkg::acs_src_e'(ctrl_reg[2:0]);
	assign preset = acs_pkg::acs_pre_e'(ctrl_reg[8:6]);
	assign act    = acs_pkg::acs_src_e'(ACTIVE_SRC);

	// spdif source is either coax or the second optical port
	assign ext_valid = {SRC_VALID[3],
		ctrl_reg[acs_pkg::CTRL_SPDIF_BIT] ? OPT2_VALID : SRC_VALID[2],
		SRC_VALID[1:0]};
	assign ext_tick = {SRC_TICK[3],
		ctrl_reg[acs_pkg::CTRL_SPDIF_BIT] ? OPT2_TICK : SRC_TICK[2],
		SRC_TICK[1:0]};

	// measurement gate
	assign gate = (gate_cnt_reg == 32'(GATE_CYC - 1));
	always_ff @(posedge MCLK) begin
		if (RST || gate) begin
			gate_cnt_reg <= '0;
		end else begin
			gate_cnt_reg <= gate_cnt_reg + 32'h1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < acs_pkg::N_EXT; gi++) begin : g_in
			acs_meas_if mi ();
			assign mi.tick = ext_tick[gi];
			assign mi.gate = gate;
			assign meas[gi] = mi.rate;
			acs_meter u_acs_meter (.clk(MCLK), .rst(RST), .m(mi));
			// sync means locked at the rate now in use
			always_comb begin
				if (!ext_valid[gi]) begin
					lock_st[gi] = 2'(acs_pkg::ST_NOLOCK);
				end else if ((meas[gi] >= cur_rate ?
						meas[gi] - cur_rate : cur_rate - meas[gi])
						<= RW'(acs_pkg::SYNC_TOL_HZ)) begin
					lock_st[gi] = 2'(acs_pkg::ST_SYNC);
				end else begin
					lock_st[gi] = 2'(acs_pkg::ST_LOCK);
				end
			end
		end
	endgenerate

	// pitch: fine offset plus preset, clamped to the 5 % window
	always_comb begin
		lim_u = base_reg / RW'(acs_pkg::PITCH_LIM_DIV);
		pre_u = '0;
		pre_s = '0;
		unique case (preset)
			acs_pkg::PRE_UP_SMALL, acs_pkg::PRE_DN_SMALL:
				pre_u = base_reg / RW'(acs_pkg::PULL_SMALL_DIV);
			acs_pkg::PRE_UP_LARGE, acs_pkg::PRE_DN_LARGE:
				pre_u = base_reg / RW'(acs_pkg::PULL_LARGE_DIV);
			default: pre_u = '0;
		endcase
		if (preset == acs_pkg::PRE_DN_SMALL ||
				preset == acs_pkg::PRE_DN_LARGE) begin
			pre_s = -$signed({2'b00, pre_u});
		end else begin
			pre_s = $signed({2'b00, pre_u});
		end
		lim_s = $signed({2'b00, lim_u});
		tot_s = fine_reg + pre_s;
		if (tot_s > lim_s) begin
			tot_s = lim_s;
		end else if (tot_s < -lim_s) begin
			tot_s = -lim_s;
		end
		// offsets only while the internal synthesizer is in use
		if (act == acs_pkg::SRC_INT) begin
			int_rate = RW'($signed({2'b00, base_reg}) + tot_s);
		end else begin
			int_rate = base_reg;
		end
	end

	// digital_frequency_synthesizer: phase accumulator in Hz units
	assign acc_sum  = acc_reg + 29'(int_rate);
	assign dds_tick = (acc_sum >= 29'(acs_pkg::CLK_HZ));
	always_ff @(posedge MCLK) begin
		if (RST) begin
			acc_reg <= '0;
		end else if (dds_tick) begin
			acc_reg <= acc_sum - 29'(acs_pkg::CLK_HZ);
		end else begin
			acc_reg <= acc_sum;
		end
	end

	// preferred input first, then the following ones in turn
	always_comb begin
		sel_next = acs_pkg::SRC_INT;
		found    = 1'b0;
		idx      = '0;
		if (pref inside {acs_pkg::SRC_WORD, acs_pkg::SRC_OPT,
				acs_pkg::SRC_SPDIF, acs_pkg::SRC_TC}) begin
			for (int k = 0; k < acs_pkg::N_EXT; k++) begin
				idx = 2'(ctrl_reg[2:0] - 3'h1 + 3'(k));
				if (!found && ext_valid[idx]) begin
					found    = 1'b1;
					sel_next = acs_pkg::acs_src_e'(3'(idx) + 3'h1);
				end
			end
		end
	end

	// active source and master flag change in the same edge
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ACTIVE_SRC <= 3'(acs_pkg::SRC_INT);
			MASTER     <= 1'b1;
		end else begin
			ACTIVE_SRC <= 3'(sel_next);
			MASTER     <= (sel_next == acs_pkg::SRC_INT);
		end
	end

	assign cur_rate = (act == acs_pkg::SRC_INT) ? int_rate :
		meas[2'(ACTIVE_SRC - 3'h1)];
	assign chosen_tick = (act == acs_pkg::SRC_INT) ? dds_tick :
		ext_tick[2'(ACTIVE_SRC - 3'h1)];
	// a switch may put two ticks close together; hold off the second
	assign pass_tick = chosen_tick &&
		(gap_reg >= 9'(acs_pkg::MIN_GAP_CYC - 1));

	always_ff @(posedge MCLK) begin
		if (RST) begin
			gap_reg <= '0;
		end else if (pass_tick) begin
			gap_reg <= '0;
		end else if (gap_reg != '1) begin
			gap_reg <= gap_reg + 9'h1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			SAMPLE_TICK <= 1'b0;
		end else begin
			SAMPLE_TICK <= pass_tick;
		end
	end

	// word clock divider for single speed
	always_comb begin
		if (!ctrl_reg[acs_pkg::CTRL_SS_BIT] ||
				cur_rate <= RW'(acs_pkg::SS_MAX_HZ)) begin
			wdiv_max = 3'h0;
		end else if (cur_rate <= RW'(acs_pkg::DIV2_MAX_HZ)) begin
			wdiv_max = 3'h1;
		end else begin
			wdiv_max = 3'h3;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			wdiv_reg <= '0;
			WCK_OUT  <= 1'b0;
		end else begin
			WCK_OUT <= pass_tick && ({1'b0, wdiv_reg} >= wdiv_max);
			if (pass_tick) begin
				wdiv_reg <= ({1'b0, wdiv_reg} >= wdiv_max) ? 2'h0 :
					wdiv_reg + 2'h1;
			end
		end
	end

	// axi4-lite write channel
	assign wr_fire = aw_have_reg && w_have_reg && !BVALID;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			AWREADY     <= 1'b0;
			WREADY      <= 1'b0;
			BVALID      <= 1'b0;
			BRESP       <= 2'h0;
		end else begin
			AWREADY <= !aw_have_reg && !(AWVALID && AWREADY);
			WREADY  <= !w_have_reg && !(WVALID && WREADY);
			if (AWVALID && AWREADY) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_have_reg <= 1'b1;
				w_data_reg <= WDATA;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				BVALID      <= 1'b1;
				BRESP       <= (aw_addr_reg inside {acs_pkg::CTRL_OFS,
					acs_pkg::BASE_OFS, acs_pkg::PITCH_OFS,
					acs_pkg::STEP_OFS}) ? 2'h0 : 2'h2;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// register writes act on the next edge, no commit needed
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ctrl_reg       <= acs_pkg::CTRL_RST;
			base_reg       <= acs_pkg::BASE_RST;
			OPT2_OUT_SPDIF <= 1'b0;
		end else begin
			OPT2_OUT_SPDIF <= ctrl_reg[acs_pkg::CTRL_OPT2O_BIT];
			if (wr_fire && aw_addr_reg == acs_pkg::CTRL_OFS) begin
				ctrl_reg <= w_data_reg[8:0];
			end
			if (wr_fire && aw_addr_reg == acs_pkg::BASE_OFS) begin
				base_reg <= w_data_reg[RW-1:0];
			end
		end
	end

	always_comb begin
		fine_next = fine_reg;
		if (w_data_reg[acs_pkg::STEP_FINE_UP]) begin
			fine_next = fine_reg + 20'(acs_pkg::FINE_STEP_HZ);
		end else if (w_data_reg[acs_pkg::STEP_FINE_DN]) begin
			fine_next = fine_reg - 20'(acs_pkg::FINE_STEP_HZ);
		end else if (w_data_reg[acs_pkg::STEP_COARSE_UP]) begin
			fine_next = fine_reg + 20'(acs_pkg::COARSE_STEP_HZ);
		end else if (w_data_reg[acs_pkg::STEP_COARSE_DN]) begin
			fine_next = fine_reg - 20'(acs_pkg::COARSE_STEP_HZ);
		end else if (w_data_reg[acs_pkg::STEP_ZERO]) begin
			fine_next = '0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			fine_reg <= '0;
		end else if (wr_fire && aw_addr_reg == acs_pkg::PITCH_OFS) begin
			fine_reg <= $signed(w_data_reg[19:0]);
		end else if (wr_fire && aw_addr_reg == acs_pkg::STEP_OFS) begin
			fine_reg <= fine_next;
		end
	end

	// axi4-lite read channel
	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		unique case (ARADDR)
			acs_pkg::CTRL_OFS:  rd_data = 32'(ctrl_reg);
			acs_pkg::BASE_OFS:  rd_data = 32'(base_reg);
			acs_pkg::PITCH_OFS: rd_data = 32'(fine_reg);
			acs_pkg::STATUS_OFS: begin
				rd_data[2:0] = ACTIVE_SRC;
				rd_data[acs_pkg::STAT_MST_BIT] = MASTER;
				rd_data[11:4] = {lock_st[3], lock_st[2],
					lock_st[1], lock_st[0]};
				rd_data[14:12] = ctrl_reg[2:0];
			end
			acs_pkg::RATE_OFS:        rd_data = 32'(cur_rate);
			acs_pkg::MEAS_OFS:        rd_data = 32'(meas[0]);
			acs_pkg::MEAS_OFS + 8'h4: rd_data = 32'(meas[1]);
			acs_pkg::MEAS_OFS + 8'h8: rd_data = 32'(meas[2]);
			acs_pkg::MEAS_OFS + 8'hc: rd_data = 32'(meas[3]);
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= 2'h0;
		end else begin
			ARREADY <= !RVALID && !(ARVALID && ARREADY);
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= rd_data;
				RRESP  <= rd_ok ? 2'h0 : 2'h2;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	a_pref_taken: assert property (
		pref != acs_pkg::SRC_INT && pref <= acs_pkg::SRC_TC &&
		ext_valid[2'(ctrl_reg[2:0] - 3'h1)] |=>
		ACTIVE_SRC == $past(ctrl_reg[2:0]))
		else $error("valid preferred input not used");
	a_fallback_next: assert property (
		pref == acs_pkg::SRC_WORD && !ext_valid[0] && ext_valid[1] |=>
		act == acs_pkg::SRC_OPT)
		else $error("fallback did not take next valid input");
	a_none_internal: assert property (
		ext_valid == 4'h0 |=> act == acs_pkg::SRC_INT && MASTER)
		else $error("no valid input but not master");
	a_master_flag: assert property (
		MASTER == (act == acs_pkg::SRC_INT))
		else $error("master flag out of step with active source");
	a_wck_plain: assert property (
		!ctrl_reg[acs_pkg::CTRL_SS_BIT] |-> ##1 WCK_OUT == SAMPLE_TICK)
		else $error("word clock differs from sample tick");
	a_wck_single: assert property (
		ctrl_reg[acs_pkg::CTRL_SS_BIT] &&
		cur_rate > RW'(acs_pkg::DIV2_MAX_HZ) && pass_tick &&
		wdiv_reg == 2'h0 |=> !WCK_OUT)
		else $error("single speed word clock not divided");
	a_nolock_state: assert property (
		!ext_valid[0] |-> lock_st[0] == 2'(acs_pkg::ST_NOLOCK))
		else $error("lost input reported as locked");
	// checks the rate handed to the synthesizer, not the clamp itself
	a_pitch_window: assert property (
		act == acs_pkg::SRC_INT |->
		{1'b0, int_rate} <= {1'b0, base_reg} + {1'b0, lim_u} &&
		{1'b0, int_rate} + {1'b0, lim_u} >= {1'b0, base_reg})
		else $error("pitch offset outside window");
	a_coarse_step: assert property (
		wr_fire && aw_addr_reg == acs_pkg::STEP_OFS &&
		w_data_reg[4:0] == 5'h04 |=>
		fine_reg == $past(fine_reg) + 20'sd50)
		else $error("coarse step not 50 Hz");
	a_slave_no_pitch: assert property (
		act != acs_pkg::SRC_INT |-> int_rate == base_reg)
		else $error("pitch applied while slaved");
	a_spdif_mux: assert property (
		ctrl_reg[acs_pkg::CTRL_SPDIF_BIT] |-> ext_valid[2] == OPT2_VALID)
		else $error("spdif input not taken from optical port");
	a_opt2_fmt: assert property (
		##1 OPT2_OUT_SPDIF == $past(ctrl_reg[acs_pkg::CTRL_OPT2O_BIT]))
		else $error("optical output format not following control");
	a_write_now: assert property (
		wr_fire && aw_addr_reg == acs_pkg::CTRL_OFS |=>
		ctrl_reg == $past(w_data_reg[8:0]))
		else $error("control write not applied at once");
	a_tick_gap: assert property (
		SAMPLE_TICK |=> !SAMPLE_TICK [*8])
		else $error("sample ticks too close");

	c_fallback: cover property (
		pref == acs_pkg::SRC_WORD ##1 act == acs_pkg::SRC_OPT);
	c_master_pitch: cover property (MASTER && tot_s != '0 && dds_tick);
	c_single_speed: cover property (
		ctrl_reg[acs_pkg::CTRL_SS_BIT] && wdiv_max == 3'h3 && WCK_OUT);
	c_sync_state: cover property (lock_st[1] == 2'(acs_pkg::ST_SYNC));
endmodule
`default_nettype wire

// >>> acs_pkg.sv
// Purpose: constants and types for the sample clock source selector
// Assumes: one 100 MHz clock, AXI4-Lite register access
// Notes: rates are held in Hz; register map is word aligned
package acs_pkg;
	localparam int CLK_HZ      = 32'h05f5e100; // 100 MHz
	localparam int MAX_RATE_HZ = 32'h00033450; // 210 kHz
	localparam int MIN_GAP_CYC = CLK_HZ / MAX_RATE_HZ;
	localparam int RATE_W      = 18;
	localparam int N_EXT       = 4;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] BASE_OFS   = 8'h04;
	localparam logic [7:0] PITCH_OFS  = 8'h08;
	localparam logic [7:0] STEP_OFS   = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] RATE_OFS   = 8'h14;
	localparam logic [7:0] MEAS_OFS   = 8'h20;
	// control fields
	localparam int CTRL_PREF_LSB   = 0;
	localparam int CTRL_SS_BIT     = 3;
	localparam int CTRL_SPDIF_BIT  = 4;
	localparam int CTRL_OPT2O_BIT  = 5;
	localparam int CTRL_PRESET_LSB = 6;
	// step command bits
	localparam int STEP_FINE_UP   = 0;
	localparam int STEP_FINE_DN   = 1;
	localparam int STEP_COARSE_UP = 2;
	localparam int STEP_COARSE_DN = 3;
	localparam int STEP_ZERO      = 4;
	// status fields
	localparam int STAT_ACT_LSB  = 0;
	localparam int STAT_MST_BIT  = 3;
	localparam int STAT_LOCK_LSB = 4;
	localparam int STAT_PREF_LSB = 12;
	// reset values
	localparam logic [8:0]        CTRL_RST = 9'h000;
	localparam logic [RATE_W-1:0] BASE_RST = 18'h0bb80; // 48 kHz
	// rate figures
	localparam int FINE_STEP_HZ   = 32'h00000001;
	localparam int COARSE_STEP_HZ = 32'h00000032; // 50 Hz
	localparam int SS_MAX_HZ      = 32'h0000bb80; // 48 kHz
	localparam int DIV2_MAX_HZ    = 32'h00017700; // 96 kHz
	localparam int PITCH_LIM_DIV  = 32'h00000014; // 1/20 = 5 %
	localparam int PULL_SMALL_DIV = 32'h000003e8; // 0.1 %
	localparam int PULL_LARGE_DIV = 32'h00000019; // 4 %
	localparam int SYNC_TOL_HZ    = 32'h00000002;

	typedef enum logic [2:0] {
		SRC_INT, SRC_WORD, SRC_OPT, SRC_SPDIF, SRC_TC
	} acs_src_e;
	typedef enum logic [1:0] {ST_NOLOCK, ST_LOCK, ST_SYNC} acs_lock_e;
	typedef enum logic [2:0] {
		PRE_NONE, PRE_UP_SMALL, PRE_DN_SMALL, PRE_UP_LARGE, PRE_DN_LARGE
	} acs_pre_e;
endpackage

// >>> acs_meas_if.sv
// Purpose: carries one input's sample ticks and its measured rate
// Assumes: tick and gate are one-cycle pulses on the block clock
// Notes: rate holds the count of the last complete gate window
`timescale 1ns/1ps
`default_nettype none
interface acs_meas_if;
	logic                           tick;
	logic                           gate;
	logic [acs_pkg::RATE_W-1:0]     rate;
	modport meter (input tick, input gate, output rate);
	modport user  (output tick, output gate, input rate);
endinterface
`default_nettype wire

// >>> acs_meter.sv
// Purpose: counts sample ticks of one input over a gate window
// Assumes: gate is a one-cycle pulse once per second
// Notes: result is the rate in Hz, held until the next gate
`timescale 1ns/1ps
`default_nettype none
module acs_meter (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// tick in, rate out
	acs_meas_if.meter  m
);
	localparam int RW = acs_pkg::RATE_W;

	logic [acs_pkg::RATE_W-1:0] cnt_reg;
	logic [acs_pkg::RATE_W-1:0] rate_reg;

	assign m.rate = rate_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (m.gate) begin
			// a tick on the gate cycle opens the next window, none lost
			cnt_reg <= RW'(m.tick);
		end else if (m.tick && cnt_reg != '1) begin
			cnt_reg <= cnt_reg + RW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rate_reg <= '0;
		end else if (m.gate) begin
			rate_reg <= cnt_reg;
		end
	end

	a_meter_latch: assert property (
		@(posedge clk) disable iff (rst)
		m.gate |=> rate_reg == $past(cnt_reg))
		else $error("meter did not latch count at gate");
endmodule
`default_nettype wire

// >>> acs_src_model.sv
// Purpose: recovered input sources facing the clock selector
// Assumes: each enabled source ticks at its own fixed period
// Notes: a disabled source shows neither valid nor ticks
`timescale 1ns/1ps
`default_nettype none
module acs_src_model #(
	parameter int PER0 = 500
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// enables: word, optical, coax, timecode, second optical
	input  wire logic [4:0] en,
	// recovered inputs of the selector
	output var  logic [3:0] valid,
	output var  logic [3:0] tick,
	output var  logic       opt2_valid,
	output var  logic       opt2_tick
);
	int cnt [5];

	// periods differ so no two sources share a phase
	always_ff @(posedge clk) begin
		for (int i = 0; i < 5; i++) begin
			if (rst || !en[i] || cnt[i] >= PER0 + 30 * i - 1)
				cnt[i] <= 0;
			else
				cnt[i] <= cnt[i] + 1;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			valid[i] = en[i];
			tick[i]  = en[i] && cnt[i] == PER0 + 30 * i - 1;
		end
		opt2_valid = en[4];
		opt2_tick  = en[4] && cnt[4] == PER0 + 119;
	end
endmodule
`default_nettype wire

// >>> tb_audio_clock_source_select.sv
// Purpose: self-checking bench for the sample clock source selector
// Assumes: register map and bus timing as handed over with the design
// Notes: short measurement gate keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_audio_clock_source_select;
	localparam int GATE = 1000;
	logic        MCLK    = 0;
	logic        RST     = 1;
	logic [7:0]  AWADDR  = 0;
	logic [7:0]  ARADDR  = 0;
	logic [31:0] WDATA   = 0;
	logic        AWVALID = 0;
	logic        WVALID  = 0;
	logic        BREADY  = 0;
	logic        ARVALID = 0;
	logic        RREADY  = 0;
	logic [4:0]  en      = 0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] RDATA;
	logic [3:0]  SRC_VALID, SRC_TICK;
	logic        OPT2_VALID, OPT2_TICK, SAMPLE_TICK, WCK_OUT;
	logic        OPT2_OUT_SPDIF, MASTER;
	logic [2:0]  ACTIVE_SRC;
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          seed;
	int          cmds [7] = '{0, 0, 2, 1, 3, 4, 2};
	int          wt [5][3] = '{'{48000, 0, 1}, '{192000, 0, 1},
		'{96000, 1, 2}, '{192000, 1, 4}, '{32000, 1, 1}};

	always #5 MCLK = ~MCLK;

	acs_top #(.GATE_CYC(GATE)) u_acs_top (
		.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.SRC_VALID(SRC_VALID), .SRC_TICK(SRC_TICK),
		.OPT2_VALID(OPT2_VALID), .OPT2_TICK(OPT2_TICK),
		.SAMPLE_TICK(SAMPLE_TICK), .WCK_OUT(WCK_OUT),
		.OPT2_OUT_SPDIF(OPT2_OUT_SPDIF), .MASTER(MASTER),
		.ACTIVE_SRC(ACTIVE_SRC));

	acs_src_model u_acs_src_model (
		.clk(MCLK), .rst(RST), .en(en), .valid(SRC_VALID),
		.tick(SRC_TICK), .opt2_valid(OPT2_VALID), .opt2_tick(OPT2_TICK));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bound(input int k);
		if (k >= 200) begin
			n_fail++;
			give_verdict();
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		bit aw;
		bit w;
		@(posedge MCLK);
		AWADDR  <= a;
		WDATA   <= d;
		AWVALID <= 1;
		WVALID  <= 1;
		BREADY  <= 1;
		aw = 1;
		w = 1;
		k = 0;
		do begin
			@(posedge MCLK);
			k++;
			if (aw && AWREADY === 1'b1) begin
				aw = 0;
				AWVALID <= 0;
			end
			if (w && WREADY === 1'b1) begin
				w = 0;
				WVALID <= 0;
			end
		end while (BVALID !== 1'b1 && k < 200);
		r = BRESP;
		BREADY <= 0;
		bound(k);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		bit ar;
		@(posedge MCLK);
		ARADDR  <= a;
		ARVALID <= 1;
		RREADY  <= 1;
		ar = 1;
		k = 0;
		do begin
			@(posedge MCLK);
			k++;
			if (ar && ARREADY === 1'b1) begin
				ar = 0;
				ARVALID <= 0;
			end
		end while (RVALID !== 1'b1 && k < 200);
		d = RDATA;
		r = RRESP;
		RREADY <= 0;
		bound(k);
	endtask

	task automatic count(input int cyc, output int nt, output int nw);
		nt = 0;
		nw = 0;
		repeat (cyc) begin
			@(posedge MCLK);
			if (SAMPLE_TICK === 1'b1)
				nt++;
			if (WCK_OUT === 1'b1)
				nw++;
		end
	endtask

	// search runs upward from the preferred input, wrapping over 1..4
	function automatic int exp_act(input logic [4:0] e, input int p,
		input bit sp2);
		logic [4:1] v;
		int         s;
		v = {e[3], sp2 ? e[4] : e[2], e[1], e[0]};
		if (p < 1 || p > 4)
			return 0;
		for (int i = 0; i < 4; i++) begin
			s = (p - 1 + i) % 4 + 1;
			if (v[s])
				return s;
		end
		return 0;
	endfunction

	function automatic int exp_rate(input int b, input int f, input int p);
		int o;
		int l;
		o = f;
		case (p)
			1: o += b / acs_pkg::PULL_SMALL_DIV;
			2: o -= b / acs_pkg::PULL_SMALL_DIV;
			3: o += b / acs_pkg::PULL_LARGE_DIV;
			4: o -= b / acs_pkg::PULL_LARGE_DIV;
			default: ;
		endcase
		l = b / acs_pkg::PITCH_LIM_DIV;
		if (o > l)
			o = l;
		if (o < -l)
			o = -l;
		return b + o;
	endfunction

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [4:0]  e;
		logic [3:0]  lk;
		int          fine, pref, ctrl, nt, nw, ex, dv;
		seed = 14;
		repeat (2) @(posedge MCLK);
		RST <= 0;
		@(posedge MCLK);
		check("master_rst", 32'(MASTER), 1);
		check("active_rst", 32'(ACTIVE_SRC), 0);
		rd(acs_pkg::CTRL_OFS, d, r);
		check("ctrl_rst", d, 32'(acs_pkg::CTRL_RST));
		rd(acs_pkg::BASE_OFS, d, r);
		check("base_rst", d, 32'(acs_pkg::BASE_RST));
		rd(acs_pkg::STEP_OFS, d, r);
		check("step_rd_resp", 32'(r), 2);
		check("step_rd_data", d, 0);
		wr(8'h3c, 32'h1, r);
		check("unmapped_wr", 32'(r), 2);
		fine = 0;
		foreach (cmds[i]) begin
			wr(acs_pkg::STEP_OFS, 32'h1 << cmds[i], r);
			case (cmds[i])
				0: fine += acs_pkg::FINE_STEP_HZ;
				1: fine -= acs_pkg::FINE_STEP_HZ;
				2: fine += acs_pkg::COARSE_STEP_HZ;
				3: fine -= acs_pkg::COARSE_STEP_HZ;
				default: fine = 0;
			endcase
			rd(acs_pkg::RATE_OFS, d, r);
			check("rate_step", d, exp_rate(48000, fine, 0));
		end
		wr(acs_pkg::PITCH_OFS, 32'h00001388, r);
		rd(acs_pkg::RATE_OFS, d, r);
		check("rate_clamp_hi", d, exp_rate(48000, 5000, 0));
		wr(acs_pkg::PITCH_OFS, 32'hffffec78, r);
		rd(acs_pkg::RATE_OFS, d, r);
		check("rate_clamp_lo", d, exp_rate(48000, -5000, 0));
		wr(acs_pkg::PITCH_OFS, 32'h0, r);
		for (int p = 1; p <= 4; p++) begin
			wr(acs_pkg::CTRL_OFS, 32'(p) << 6, r);
			rd(acs_pkg::RATE_OFS, d, r);
			check("rate_preset", d, exp_rate(48000, 0, p));
		end
		// pitch set, but an external reference must pass untouched
		wr(acs_pkg::PITCH_OFS, 32'h00000960, r);
		wr(acs_pkg::CTRL_OFS, 32'h1, r);
		en <= 5'h01;
		count(8000, nt, nw);
		check("master_ext", 32'(MASTER), 0);
		check("ext_ticks", 32'(nt >= 15 && nt <= 16), 1);
		en <= 5'h00;
		repeat (2) @(posedge MCLK);
		check("fallback", 32'(ACTIVE_SRC), 0);
		// back on the synthesizer the stored offset applies again
		rd(acs_pkg::RATE_OFS, d, r);
		check("rate_master", d, exp_rate(48000, 2400, 0));
		wr(acs_pkg::PITCH_OFS, 32'h0, r);
		foreach (wt[i]) begin
			dv = wt[i][2];
			wr(acs_pkg::CTRL_OFS, 32'(wt[i][1]) << 3, r);
			// rate changed only with no stream running
			wr(acs_pkg::BASE_OFS, 32'(wt[i][0]), r);
			// settle pause before counting, scaled down
			repeat (500) @(posedge MCLK);
			count(8000, nt, nw);
			check("wck_div", 32'(nw * dv > nt - dv && nw * dv < nt + dv),
				1);
			ex = int'(64'(wt[i][0]) * 8000 / acs_pkg::CLK_HZ);
			check("tick_rate", 32'(nt >= ex - 1 && nt <= ex + 1), 1);
		end
		wr(acs_pkg::BASE_OFS, 32'h0000bb80, r);
		repeat (16) begin
			e = 5'($random(seed));
			pref = $random(seed) & 7;
			ctrl = pref | ($random(seed) & 32'h30);
			wr(acs_pkg::CTRL_OFS, 32'(ctrl), r);
			en <= e;
			repeat (2) @(posedge MCLK);
			ex = exp_act(e, pref, ctrl[4]);
			check("active", 32'(ACTIVE_SRC), 32'(ex));
			check("master", 32'(MASTER), 32'(ex == 0));
			check("opt2_out", 32'(OPT2_OUT_SPDIF), 32'(ctrl[5]));
			rd(acs_pkg::STATUS_OFS, d, r);
			check("stat_act", 32'(d[3:0]), {ex == 0, 3'(ex)});
			check("stat_pref", 32'(d[14:12]), 32'(pref));
			lk = {e[3], ctrl[4] ? e[4] : e[2], e[1], e[0]};
			for (int i = 0; i < 4; i++)
				check("lock", 32'(d[4 + 2 * i +: 2] != 0), 32'(lk[i]));
		end
		en <= 5'h01;
		repeat (2500) @(posedge MCLK);
		rd(acs_pkg::MEAS_OFS, d, r);
		check("meas_word", d, GATE / 500);
		give_verdict();
	end
endmodule
`default_nettype wire
